/* testbench/tsx_decode_exec_asserts.sv */
// Checker for the test-and-skip / xor-literal block, bound to its instances.
// Assumes a word is taken at a rising mclk edge with phase_ack and instr_valid.
`default_nettype none
module tsx_decode_exec_asserts import tsx_pkg::*; (
    input wire logic          mclk,
    input wire logic          rst_n,
    input wire logic          instr_valid,
    input wire logic [15:0]   instr_word,
    input wire logic [3:0]    bank_selection_reg,
    input wire logic          ext_set_enable,
    input wire logic [7:0]    mem_rdata,
    input wire logic          phase_ack,
    input wire tsx_addr_type  mem_addr,
    input wire logic [7:0]    accumulator,
    input wire tsx_flags_type flags,
    input wire logic          flags_we,
    input wire logic          skip_taken,
    input wire logic          idle_cycle,
    input wire logic          cycle_end
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // A discarded word shows idle_cycle one edge after it was taken.
    wire tk = phase_ack && instr_valid;
    wire tx = tk && instr_word[15:8] == OPC_XOR_LIT;
    wire tt = tk && instr_word[15:9] == OPC_TEST_SKIP;
    wire [7:0] f = instr_word[7:0];
    a_xor_result:
        assert property (tx ##2 !idle_cycle |-> ##2 flags_we && accumulator ==
            ($past(accumulator, 1) ^ $past(f, 4))) else $error("xor result wrong");
    a_xor_flags:
        assert property (tx ##2 !idle_cycle |-> ##2 flags == {accumulator[7],
            accumulator == 8'h00}) else $error("xor flags wrong");
    a_flags_cause:
        assert property (flags_we |-> $past(tx, 4)) else $error("stray flag write");
    a_flags_hold:
        assert property (!flags_we && $past(rst_n) |-> $stable(flags) && $stable(accumulator))
            else $error("state changed without write");
    // Access bank splits at ACC_SPLIT; indexed mode only with the extended set.
    a_access_bank:
        assert property (tt && !instr_word[8] ##2 !idle_cycle |-> ##1 mem_addr.valid &&
            mem_addr.offset == $past(f, 3) && mem_addr.bank == ($past(f, 3) < ACC_SPLIT ?
            4'h0 : TOP_BANK) && mem_addr.indexed == ($past(ext_set_enable, 2) &&
            $past(f, 3) <= IDX_LIMIT)) else $error("access bank address wrong");
    a_bank_reg:
        assert property (tt && instr_word[8] ##2 !idle_cycle |-> ##1 mem_addr.valid &&
            mem_addr.bank == $past(bank_selection_reg, 2) && !mem_addr.indexed)
            else $error("bank wrong");
    a_skip_zero:
        assert property (tt ##2 !idle_cycle |-> ##2 skip_taken ==
            ($past(mem_rdata, 2) == 8'h00)) else $error("skip decision wrong");
    a_idle_next:
        assert property ($rose(skip_taken) && tk |=> idle_cycle) else $error("no idle");
    a_two_word:
        assert property ($rose(skip_taken) && tk && instr_word[15:13] == 3'h7
            ##4 tk |=> idle_cycle) else $error("second word not idled");
    c_xor: cover property (tx ##2 !idle_cycle);
    c_skip: cover property ($rose(skip_taken));
    c_two: cover property ($rose(skip_taken) && tk && instr_word[15:13] == 3'h7);
endmodule
bind tsx_decode_exec tsx_decode_exec_asserts chk_u (.*);
`default_nettype wire

/* testbench/tsx_decode_exec_tb.sv */
// Self-checking bench: one word per four-clock instruction cycle.
// Assumes the data byte is driven straight onto mem_rdata for each word.
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tsx_decode_exec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tsx_pkg::*;
    logic          mclk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, ext_set_enable = 1'b0;
    logic [15:0]   instr_word = 16'h0000;
    logic [3:0]    bank_selection_reg = 4'h0;
    logic [7:0]    mem_rdata = 8'h00, accumulator;
    logic          phase_ack, flags_we, skip_taken, idle_cycle, cycle_end, end_seen;
    tsx_flags_type flags;
    tsx_addr_type  mem_addr, seen;
    int            mismatches = 0, total_checks = 0, n = 0;
    tsx_decode_exec dut_u (.*);
    // Clock of 25 ns.
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // One word per call; the word's results stand when the call returns.
    task automatic op(input logic [15:0] w, input logic [7:0] d);
        instr_word <= w;
        mem_rdata <= d;
        repeat (3) @(posedge mclk);
        #1 seen = mem_addr;
        end_seen = cycle_end;
        @(posedge mclk);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_xor;
        op(16'h0ab5, 8'h00);
        `CHK("acc", 8'hb5, accumulator)
        `CHK("flags", 2'b10, flags)
        `CHK("flags_we", 1'b1, flags_we)
        `CHK("cycle_end", 1'b1, end_seen)
        op(16'h0aaf, 8'h00);
        `CHK("acc", 8'h1a, accumulator)
        op(16'h0a1a, 8'h00);
        `CHK("acc", 8'h00, accumulator)
        op(16'h0000, 8'h00);
        `CHK("flags", 2'b01, flags)
        `CHK("flags_we", 1'b0, flags_we)
    endtask
    // A zero byte discards the xor behind it; a nonzero byte lets it run.
    task automatic t_skip;
        op(16'h6610, 8'h00);
        `CHK("bank", 4'h0, seen.bank)
        `CHK("offset", 8'h10, seen.offset)
        `CHK("skip", 1'b1, skip_taken)
        `CHK("flags_we", 1'b0, flags_we)
        op(16'h0a55, 8'h00);
        `CHK("idle", 1'b1, idle_cycle)
        `CHK("flags", 2'b01, flags)
        op(16'h0000, 8'h00);
        `CHK("acc", 8'h00, accumulator)
        `CHK("idle", 1'b0, idle_cycle)
        bank_selection_reg <= 4'h5;
        op(16'h6780, 8'h01);
        `CHK("bank", 4'h5, seen.bank)
        `CHK("skip", 1'b0, skip_taken)
        op(16'h0a55, 8'h00);
        `CHK("acc", 8'h55, accumulator)
    endtask
    // Skipping a two-word instruction also discards its second word.
    task automatic t_two;
        ext_set_enable <= 1'b1;
        op(16'h665f, 8'h00);
        `CHK("indexed", 1'b1, seen.indexed)
        op(16'hf123, 8'h00);
        `CHK("idle", 1'b1, idle_cycle)
        op(16'h0a0f, 8'h00);
        `CHK("idle", 1'b1, idle_cycle)
        op(16'h0a01, 8'h00);
        `CHK("acc", 8'h54, accumulator)
        `CHK("idle", 1'b0, idle_cycle)
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        instr_valid <= 1'b1;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (!phase_ack && n < 8);
        if (!phase_ack) mismatches++;
        if (phase_ack) t_xor();
        if (phase_ack) t_skip();
        if (phase_ack) t_two();
        final_report();
    end
endmodule
`default_nettype wire

/* verilog/tsx_decode_exec.sv */
// Decode and execute of the test-and-skip and xor-literal instructions.
// Assumes the fetch unit presents a word with instr_valid at each decode phase
// and the data memory returns the addressed byte by the process phase.
`default_nettype none
module tsx_decode_exec (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  instr_valid,
    input  wire logic [15:0]           instr_word,
    input  wire logic [3:0]            bank_selection_reg,
    input  wire logic                  ext_set_enable,
    input  wire logic [7:0]            mem_rdata,
    output logic                       phase_ack,
    output tsx_pkg::tsx_addr_type      mem_addr,
    output logic [7:0]                 accumulator,
    output tsx_pkg::tsx_flags_type     flags,
    output logic                       flags_we,
    output logic                       skip_taken,
    output logic                       idle_cycle,
    output logic                       cycle_end
);
    import tsx_pkg::*;

    // Timing of one taken word, counted in rising mclk edges from the take edge:
    //   edge 0: the word is latched while phase_ack is high (decode phase).
    //   edge 1: the operand address is registered (read phase ends).
    //   edge 2: the data byte or the literal is combined (process phase ends).
    //   edge 3: accumulator, flags, flags_we and skip_taken are registered.
    // So skip_taken and flags_we stand from edge 3 to the next take edge, accumulator and flags to the next write, and the
    // word taken right after a zero test is already marked idle at its own take
    // edge. The address request stays up through process and write phases,
    // which gives the datapath one mclk period, up to edge 2, to return the byte.
    // Limitation: two-word detection only looks at the top nibble, so a word
    // with that prefix that is really an operand word is treated the same way.

    // Step of one for the skip counter.
    localparam logic [1:0] SKIP_ONE = 2'd1;

    function automatic logic is_two_word(input logic [15:0] w);
        is_two_word = (w[15:12] == OPC_TWO_WORD) || (w[15:12] == OPC_LFSR_HI);
    endfunction

    // Access bank split: field values below ACC_SPLIT in bank zero, the rest on top.
    function automatic logic [3:0] access_bank(input logic [7:0] f);
        access_bank = (f >= ACC_SPLIT) ? TOP_BANK : 4'h0;
    endfunction

    tsx_phase_type phase, next_phase;
    logic [15:0]   cur, next_cur;
    logic          busy, next_busy;
    logic [1:0]    skip_left, next_skip_left;
    logic          skip_armed, next_skip_armed;
    logic [7:0]    operand, next_operand;
    tsx_addr_type  next_mem_addr;
    logic [7:0]    next_accumulator;
    tsx_flags_type next_flags;
    logic          next_flags_we, next_skip_taken, next_idle_cycle;
    logic          is_test, is_xor;
    logic          skip_hit, take_idle;

    assign is_test   = cur[15:9] == OPC_TEST_SKIP;
    assign is_xor    = cur[15:8] == OPC_XOR_LIT;
    assign phase_ack = phase == PH_DECODE;
    assign cycle_end = phase == PH_WRITE;

    // A zero test decided in the write phase, and a word that must be dropped.
    // The skip tracker uses both; the datapath uses only take_idle.
    assign skip_hit  = cycle_end && busy && is_test && (operand == 8'h00);
    assign take_idle = phase_ack && instr_valid && (skip_left != 2'd0);

    // Phase sequencer: the four phases of a cycle simply rotate.
    always_comb begin
        next_phase = tsx_phase_type'(phase + 2'd1);
    end

    // Phase register; reset restarts in the decode phase.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase <= PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    // Skip tracker: counts the words still to be discarded after a zero test.
    // The armed bit lets only the first victim extend the skip to two words.
    always_comb begin
        next_skip_left  = skip_left;
        next_skip_armed = skip_armed;
        next_skip_taken = skip_taken;
        next_idle_cycle = idle_cycle;
        if (phase_ack) begin
            next_skip_taken = 1'b0;
            next_idle_cycle = 1'b0;
        end
        if (take_idle) begin
            // Discarded word: no work in any phase.
            next_idle_cycle = 1'b1;
            // A two-word victim also idles its second word.
            if (skip_armed && is_two_word(instr_word)) begin
                next_skip_left = SKIP_ONE;
            end else begin
                next_skip_left = skip_left - SKIP_ONE;
            end
            next_skip_armed = 1'b0;
        end
        if (skip_hit) begin
            // Flags untouched; the prefetched word will be idled.
            next_skip_left  = SKIP_ONE;
            next_skip_armed = 1'b1;
            next_skip_taken = 1'b1;
        end
    end

    // Skip tracker registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            skip_left  <= 2'd0;
            skip_armed <= 1'b0;
            skip_taken <= 1'b0;
            idle_cycle <= 1'b0;
        end else begin
            skip_left  <= next_skip_left;
            skip_armed <= next_skip_armed;
            skip_taken <= next_skip_taken;
            idle_cycle <= next_idle_cycle;
        end
    end

    // Datapath: operand fetch, combine and write-back, one step per phase.
    // Writes to the accumulator and flags happen only in the write phase.
    always_comb begin
        next_cur         = cur;
        next_busy        = busy;
        next_operand     = operand;
        next_mem_addr    = mem_addr;
        next_accumulator = accumulator;
        next_flags       = flags;
        next_flags_we    = 1'b0;
        unique case (phase)
            PH_DECODE: begin
                // A discarded word is latched but never marked busy.
                next_cur  = instr_word;
                next_busy = instr_valid && !take_idle;
            end
            PH_READ: begin
                next_mem_addr = '0;
                if (busy && is_test) begin
                    next_mem_addr.valid  = 1'b1;
                    next_mem_addr.offset = cur[7:0];
                    if (cur[ACC_SEL_BIT]) begin
                        next_mem_addr.bank = bank_selection_reg;
                    end else if (ext_set_enable && cur[7:0] <= IDX_LIMIT) begin
                        next_mem_addr.indexed = 1'b1;
                    end else begin
                        next_mem_addr.bank = access_bank(cur[7:0]);
                    end
                end
                if (busy && is_xor) begin
                    next_operand = cur[7:0];
                end
            end
            PH_PROCESS: begin
                if (busy && is_test) begin
                    next_operand = mem_rdata;
                end else if (busy && is_xor) begin
                    next_operand = accumulator ^ operand;
                end
            end
            PH_WRITE: begin
                // The test result only feeds the skip tracker.
                next_mem_addr = '0;
                if (busy && is_xor) begin
                    next_accumulator = operand;
                    next_flags.neg   = operand[7];
                    next_flags.zero  = operand == 8'h00;
                    next_flags_we    = 1'b1;
                end
                next_busy = 1'b0;
            end
        endcase
    end

    // Datapath registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cur         <= '0;
            busy        <= 1'b0;
            operand     <= '0;
            mem_addr    <= '0;
            accumulator <= '0;
            flags       <= '0;
            flags_we    <= 1'b0;
        end else begin
            cur         <= next_cur;
            busy        <= next_busy;
            operand     <= next_operand;
            mem_addr    <= next_mem_addr;
            accumulator <= next_accumulator;
            flags       <= next_flags;
            flags_we    <= next_flags_we;
        end
    end
endmodule
`default_nettype wire

/* verilog/tsx_pkg.sv */
// Package for the test-and-skip / xor-literal decode and execute block.
// Assumes one core clock; each instruction cycle is four phases of that clock.
`default_nettype none
package tsx_pkg;
    // Opcode fields of the 16-bit instruction word.
    localparam logic [6:0] OPC_TEST_SKIP = 7'h33;   // Bits 15:9 = 0110 011.
    localparam logic [7:0] OPC_XOR_LIT   = 8'h0a;   // Bits 15:8 = 0000 1010.
    localparam int         ACC_SEL_BIT   = 8;       // Access-select bit position.
    // Indexed literal offset window upper limit in the register field.
    localparam logic [7:0] IDX_LIMIT     = 8'h5f;
    // Access bank: values below ACC_SPLIT map to bank zero, the rest to the top bank.
    localparam logic [7:0] ACC_SPLIT     = 8'h60;
    localparam logic [3:0] TOP_BANK      = 4'hf;
    // Two-word instructions carry OPC_TWO_WORD or OPC_LFSR_HI in bits 15:12.
    localparam logic [3:0] OPC_TWO_WORD  = 4'hf;
    localparam logic [3:0] OPC_LFSR_HI   = 4'he;
    localparam logic [3:0] OPC_LFSR_LO   = 4'he;

    // Four phases of one instruction cycle.
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } tsx_phase_type;

    // Status flags touched by this block.
    typedef struct packed {
        logic neg;
        logic zero;
    } tsx_flags_type;

    // Data-memory address request towards the datapath.
    typedef struct packed {
        logic       valid;
        logic       indexed;  // Address is index register plus offset.
        logic [3:0] bank;
        logic [7:0] offset;
    } tsx_addr_type;
endpackage
`default_nettype wire
